// file: design/dsl_serial_params.svh
// constants for the bit-pump serial port
`ifndef DSL_SERIAL_PARAMS_SVH
`define DSL_SERIAL_PARAMS_SVH

// symbol-phase clock level that marks each bit position
`define PHASE_SIGN_LEVEL 1'b0
`define PHASE_MAG_LEVEL  1'b1

// symbol sent when no user symbol is waiting
`define IDLE_SIGN        1'b0
`define IDLE_MAG         1'b0

// reset values
`define TOGGLE_RESET     1'b0
`define LINE_TX_RESET    1'b0
`define RX_DATA_RESET    1'b0
`define SYNC_RESET       3'h0
`define FLAG_RESET       1'b0

`endif

// file: design/dsl_serial_pkg.sv
// types for the bit-pump serial port
package dsl_serial_pkg;

  // which half of a symbol the next launched bit is
  typedef enum logic
  {
    POS_SIGN,
    POS_MAG
  } bit_pos_e;

  // three-stage synchroniser chain
  typedef logic [2:0] sync_t;

endpackage

// file: design/dsl_bitpump_serial_port.sv
// serial line port between framer core and a 2B1Q bit pump
`timescale 1ns/1ps
`include "dsl_serial_params.svh"

module dsl_bitpump_serial_port
  import dsl_serial_pkg::*;
(
  // system clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // mode strap, change only while the line is idle
  input  wire logic repeater_mode,
  // source bit pump link
  input  wire logic bit_clock,
  input  wire logic symbol_phase_clock,
  input  wire logic line_rx_serial,
  output logic      line_tx_serial,
  // destination bit pump clocks, repeater only
  input  wire logic dest_pump_bit_clock,
  input  wire logic dest_pump_symbol_phase,
  // transmit symbols from the core
  input  wire logic tx_sign,
  input  wire logic tx_magnitude,
  input  wire logic tx_valid,
  output logic      tx_ready,
  // received symbols to the core
  output logic      rx_sign,
  output logic      rx_magnitude,
  output logic      rx_valid
);

  // change counts once stages two and three agree
  function automatic logic agreed_next(input sync_t chain, input logic old);
    logic res;
    res = old;
    if (chain[1] == chain[2])
    begin
      res = chain[2];
    end
    return res;
  endfunction

  // system reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // transmit clock selection
  logic tx_clk;
  logic tx_phase;

  // destination pair ignored unless repeating
  assign tx_clk   = repeater_mode ? dest_pump_bit_clock : bit_clock;
  assign tx_phase = repeater_mode ? dest_pump_symbol_phase : symbol_phase_clock;

  // link-side reset releases, one per link edge
  logic tx_rst_meta_reg;
  logic tx_rst_n_reg;
  logic rx_rst_meta_reg;
  logic rx_rst_n_reg;

  always_ff @(posedge tx_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_rst_meta_reg <= 1'b0;
      tx_rst_n_reg    <= 1'b0;
    end
    else
    begin
      tx_rst_meta_reg <= 1'b1;
      tx_rst_n_reg    <= tx_rst_meta_reg;
    end
  end

  // receive reset follows the source pump clock
  always_ff @(negedge bit_clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_rst_meta_reg <= 1'b0;
      rx_rst_n_reg    <= 1'b0;
    end
    else
    begin
      rx_rst_meta_reg <= 1'b1;
      rx_rst_n_reg    <= rx_rst_meta_reg;
    end
  end

  // system side of transmit handshake
  logic  tx_req_reg;
  logic  tx_hold_sign_reg;
  logic  tx_hold_mag_reg;
  sync_t tx_ack_sync_reg;
  logic  tx_ack_seen_reg;
  logic  tx_ack_tog_reg;

  // one symbol in flight at a time
  assign tx_ready = (tx_req_reg == tx_ack_seen_reg);

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      tx_req_reg       <= `TOGGLE_RESET;
      tx_hold_sign_reg <= `IDLE_SIGN;
      tx_hold_mag_reg  <= `IDLE_MAG;
    end
    else if (tx_valid && tx_ready)
    begin
      tx_req_reg       <= ~tx_req_reg;
      tx_hold_sign_reg <= tx_sign;
      tx_hold_mag_reg  <= tx_magnitude;
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      tx_ack_sync_reg <= `SYNC_RESET;
      tx_ack_seen_reg <= `TOGGLE_RESET;
    end
    else
    begin
      tx_ack_sync_reg <= {tx_ack_sync_reg[1:0], tx_ack_tog_reg};
      tx_ack_seen_reg <= agreed_next(tx_ack_sync_reg, tx_ack_seen_reg);
    end
  end

  // link side of transmit
  sync_t    tx_req_sync_reg;
  logic     tx_req_seen_reg;
  logic     tx_mag_reg;
  logic     tx_out_reg;
  bit_pos_e tx_next_pos;

  // phase flips on this edge, so the old level names the bit just ended
  always_comb
  begin
    case (tx_phase)
      `PHASE_MAG_LEVEL:  tx_next_pos = POS_SIGN;
      `PHASE_SIGN_LEVEL: tx_next_pos = POS_MAG;
      default:           tx_next_pos = POS_SIGN;
    endcase
  end

  always_ff @(posedge tx_clk or negedge tx_rst_n_reg)
  begin
    if (!tx_rst_n_reg)
    begin
      tx_req_sync_reg <= `SYNC_RESET;
      tx_req_seen_reg <= `TOGGLE_RESET;
    end
    else
    begin
      tx_req_sync_reg <= {tx_req_sync_reg[1:0], tx_req_reg};
      tx_req_seen_reg <= agreed_next(tx_req_sync_reg, tx_req_seen_reg);
    end
  end

  // launch one bit per rising edge
  always_ff @(posedge tx_clk or negedge tx_rst_n_reg)
  begin
    if (!tx_rst_n_reg)
    begin
      tx_ack_tog_reg <= `TOGGLE_RESET;
      tx_mag_reg     <= `IDLE_MAG;
      tx_out_reg     <= `LINE_TX_RESET;
    end
    else
    begin
      case (tx_next_pos)
        POS_SIGN:
        begin
          if (tx_req_seen_reg != tx_ack_tog_reg)
          begin
            tx_ack_tog_reg <= ~tx_ack_tog_reg;
            tx_out_reg     <= tx_hold_sign_reg;
            tx_mag_reg     <= tx_hold_mag_reg;
          end
          else
          begin
            tx_out_reg <= `IDLE_SIGN;
            tx_mag_reg <= `IDLE_MAG;
          end
        end
        POS_MAG:
        begin
          tx_out_reg <= tx_mag_reg;
        end
        default:
        begin
          tx_out_reg <= `LINE_TX_RESET;
        end
      endcase
    end
  end

  assign line_tx_serial = tx_out_reg;

  // link side of receive, source pump clock in both modes
  logic rx_sign_cap_reg;
  logic rx_have_sign_reg;
  logic rx_word_sign_reg;
  logic rx_word_mag_reg;
  logic rx_tog_reg;

  // phase is sampled on the same falling edge as data
  always_ff @(negedge bit_clock or negedge rx_rst_n_reg)
  begin
    if (!rx_rst_n_reg)
    begin
      rx_sign_cap_reg  <= `RX_DATA_RESET;
      rx_have_sign_reg <= `FLAG_RESET;
      rx_word_sign_reg <= `RX_DATA_RESET;
      rx_word_mag_reg  <= `RX_DATA_RESET;
      rx_tog_reg       <= `TOGGLE_RESET;
    end
    else if (symbol_phase_clock == `PHASE_SIGN_LEVEL)
    begin
      rx_sign_cap_reg  <= line_rx_serial;
      rx_have_sign_reg <= 1'b1;
    end
    else
    begin
      // magnitude without a preceding sign is dropped
      if (rx_have_sign_reg)
      begin
        rx_word_sign_reg <= rx_sign_cap_reg;
        rx_word_mag_reg  <= line_rx_serial;
        rx_tog_reg       <= ~rx_tog_reg;
      end
      rx_have_sign_reg <= 1'b0;
    end
  end

  // system side of receive
  sync_t rx_sync_reg;
  logic  rx_seen_reg;
  logic  rx_taken_reg;
  logic  rx_sign_reg;
  logic  rx_mag_reg;
  logic  rx_valid_reg;

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rx_sync_reg <= `SYNC_RESET;
      rx_seen_reg <= `TOGGLE_RESET;
    end
    else
    begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_tog_reg};
      rx_seen_reg <= agreed_next(rx_sync_reg, rx_seen_reg);
    end
  end

  // word stays stable for a whole symbol after its toggle
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rx_taken_reg <= `TOGGLE_RESET;
      rx_sign_reg  <= `RX_DATA_RESET;
      rx_mag_reg   <= `RX_DATA_RESET;
      rx_valid_reg <= `FLAG_RESET;
    end
    else if (rx_seen_reg != rx_taken_reg)
    begin
      rx_taken_reg <= rx_seen_reg;
      rx_sign_reg  <= rx_word_sign_reg;
      rx_mag_reg   <= rx_word_mag_reg;
      rx_valid_reg <= 1'b1;
    end
    else
    begin
      rx_valid_reg <= 1'b0;
    end
  end

  assign rx_sign      = rx_sign_reg;
  assign rx_magnitude = rx_mag_reg;
  assign rx_valid     = rx_valid_reg;

endmodule // dsl_bitpump_serial_port

// file: tb/dsl_serial_chk_sva.sv
// assertions for the bit-pump serial port
`timescale 1ns/1ps
module dsl_serial_chk (
  // watched ports
  input wire logic clock,
  input wire logic resetn,
  input wire logic repeater_mode,
  input wire logic bit_clock,
  input wire logic dest_pump_bit_clock,
  input wire logic line_tx_serial,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_sign,
  input wire logic rx_magnitude,
  input wire logic rx_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [3:0] since_fall_reg;
  // cycles since receive clock fell
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn) since_fall_reg <= 4'hf;
    else if ($fell(bit_clock)) since_fall_reg <= 4'h0;
    else if (since_fall_reg != 4'hf) since_fall_reg <= since_fall_reg + 4'h1;
  end
  a_tx_src_rise: assert property (!repeater_mode && $changed(line_tx_serial) |-> $rose(bit_clock))
    else $error("tx moved off bit clock rise");
  a_tx_dst_rise: assert property (repeater_mode && $changed(line_tx_serial) |-> $rose(dest_pump_bit_clock))
    else $error("tx moved off destination clock rise");
  a_rx_after_fall: assert property (rx_valid |-> since_fall_reg >= 4'h1 && since_fall_reg <= 4'h6)
    else $error("rx symbol not tied to falling edge");
  a_rx_spacing: assert property (rx_valid |=> !rx_valid [*8])
    else $error("rx symbols too close");
  a_rx_data_hold: assert property ($changed({rx_sign, rx_magnitude}) |-> rx_valid)
    else $error("rx data moved without valid");
  a_ready_drop: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("ready stayed up after take");
  a_ready_held: assert property ($fell(tx_ready) |-> !tx_ready [*8])
    else $error("ready back too early");
  a_ready_back: assert property ($fell(tx_ready) |-> ##[1:120] tx_ready)
    else $error("symbol never launched");
  c_tx_take: cover property (tx_valid && tx_ready);
  c_rx_sym: cover property (rx_valid);
  c_rep_tx: cover property (repeater_mode && $changed(line_tx_serial));
endmodule // dsl_serial_chk

bind dsl_bitpump_serial_port dsl_serial_chk chk_u (.clock(clock), .resetn(resetn), .repeater_mode(repeater_mode),
  .bit_clock(bit_clock), .dest_pump_bit_clock(dest_pump_bit_clock), .line_tx_serial(line_tx_serial),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_sign(rx_sign), .rx_magnitude(rx_magnitude), .rx_valid(rx_valid));

// file: tb/bit_pump_model.sv
// behavioural bit pump: line clocks, receive stream, transmit capture
`timescale 1ns/1ps
module bit_pump_model #(
  parameter real START_NS = 3.0
) (
  // control and data
  input  wire logic       run,
  input  wire logic [1:0] send_sym,
  output logic [1:0]      got_sym,
  // line side
  output logic            bclk,
  output logic            phase,
  output logic            rx_line,
  input  wire logic       tx_line
);
  logic got_sign_reg;
  initial
  begin
    bclk = 1'b0;
    phase = 1'b1;
    rx_line = 1'b0;
    got_sym = 2'h0;
    got_sign_reg = 1'b0;
    #START_NS;
    forever
    begin
      #62.5;
      if (run) bclk = ~bclk;
    end
  end
  // phase flips on each rise, next bit follows it
  always @(posedge bclk)
  begin
    phase <= ~phase;
    rx_line <= phase ? send_sym[1] : send_sym[0];
  end
  // sign while phase low, magnitude while high
  always @(negedge bclk)
    if (!phase) got_sign_reg <= tx_line;
    else got_sym <= {got_sign_reg, tx_line};
endmodule // bit_pump_model

// file: tb/dsl_bitpump_serial_port_test.sv
// self-checking bench for the bit-pump serial port
`timescale 1ns/1ps
module dsl_bitpump_serial_port_test;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic       repeater_mode = 1'b0;
  logic       tx_sign = 1'b0;
  logic       tx_magnitude = 1'b0;
  logic       tx_valid = 1'b0;
  logic [1:0] src_send = 2'h0;
  logic [1:0] src_got;
  logic [1:0] dst_got;
  logic       bit_clock, symbol_phase_clock, line_rx_serial, line_tx_serial;
  logic       dest_pump_bit_clock, dest_pump_symbol_phase, tx_ready, rx_sign, rx_magnitude, rx_valid;
  int         error_cnt = 0;
  int         total_checks = 0;
  always #5 clock = ~clock;
  bit_pump_model #(.START_NS(3.0)) src_u (.run(1'b1), .send_sym(src_send), .got_sym(src_got), .bclk(bit_clock),
    .phase(symbol_phase_clock), .rx_line(line_rx_serial), .tx_line(line_tx_serial));
  bit_pump_model #(.START_NS(7.0)) dst_u (.run(repeater_mode), .send_sym(2'h0), .got_sym(dst_got),
    .bclk(dest_pump_bit_clock), .phase(dest_pump_symbol_phase), .rx_line(), .tx_line(line_tx_serial));
  dsl_bitpump_serial_port dut_u (.clock(clock), .resetn(resetn), .repeater_mode(repeater_mode),
    .bit_clock(bit_clock), .symbol_phase_clock(symbol_phase_clock), .line_rx_serial(line_rx_serial),
    .line_tx_serial(line_tx_serial), .dest_pump_bit_clock(dest_pump_bit_clock),
    .dest_pump_symbol_phase(dest_pump_symbol_phase), .tx_sign(tx_sign), .tx_magnitude(tx_magnitude),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_sign(rx_sign), .rx_magnitude(rx_magnitude), .rx_valid(rx_valid));

  task automatic check2(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // idle first clears any stale capture, then one symbol is offered and must arrive
  task automatic tx_sym(input logic [1:0] sym, input logic rep);
    int n;
    for (n = 0; n < 100 && (rep ? dst_got : src_got) !== 2'h0; n++) @(negedge clock);
    check2(rep ? dst_got : src_got, 2'h0);
    for (n = 0; n < 200 && tx_ready !== 1'b1; n++) @(negedge clock);
    check1(tx_ready, 1'b1);
    @(posedge clock);
    #1;
    {tx_sign, tx_magnitude} = sym;
    tx_valid = 1'b1;
    @(posedge clock);
    #1;
    tx_valid = 1'b0;
    check1(tx_ready, 1'b0);
    for (n = 0; n < 300 && (rep ? dst_got : src_got) !== sym; n++) @(negedge clock);
    check2(rep ? dst_got : src_got, sym);
  endtask

  // pump repeats one symbol, second complete symbol is judged
  task automatic rx_sym(input logic [1:0] sym);
    int n;
    src_send = sym;
    repeat (2)
    begin
      for (n = 0; n < 100 && rx_valid !== 1'b1; n++) @(negedge clock);
      check1(rx_valid, 1'b1);
      @(negedge clock);
    end
    check2({rx_sign, rx_magnitude}, sym);
  endtask

  task automatic t_tx_normal();
    tx_sym(2'h2, 1'b0);
    tx_sym(2'h1, 1'b0);
    tx_sym(2'h3, 1'b0);
  endtask

  task automatic t_rx_all();
    for (int s = 0; s < 4; s++) rx_sym(s[1:0]);
  endtask

  // switch modes just after the source clock fell, so the clock mux makes no rising edge
  task automatic t_repeater();
    @(negedge bit_clock);
    @(posedge clock);
    #1;
    repeater_mode = 1'b1;
    tx_sym(2'h2, 1'b1);
    tx_sym(2'h1, 1'b1);
    rx_sym(2'h2);
    @(negedge bit_clock);
    @(posedge clock);
    #1;
    repeater_mode = 1'b0;
    tx_sym(2'h1, 1'b0);
  endtask

  // mid-run reset: outputs at rest values, then both links restart
  task automatic t_reset();
    @(posedge clock);
    #1;
    resetn = 1'b0;
    @(negedge clock);
    check1(line_tx_serial, 1'b0);
    check1(tx_ready, 1'b1);
    check1(rx_valid, 1'b0);
    check2({rx_sign, rx_magnitude}, 2'h0);
    repeat (40) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (30) @(posedge clock);
    tx_sym(2'h3, 1'b0);
    rx_sym(2'h1);
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (30) @(posedge clock);
    t_tx_normal();
    t_rx_all();
    t_repeater();
    t_reset();
    wrap_up();
  end

  initial
  begin
    #200000;
    error_cnt++;
    wrap_up();
  end
endmodule // dsl_bitpump_serial_port_test
